// ### verilog/board_ctl_pkg.sv
/*
 * constants, field layout and state types for the board control/status logic.
 * assumes a 100 MHz single clock and the processor's big-endian bit numbering on the data bus.
 */
package board_ctl_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_SAMPLE_US = 1000;
	localparam int DEBOUNCE_SAMPLE_CYCLES = (DEBOUNCE_SAMPLE_US * 1000) / CLK_PERIOD_NS;
	localparam int DEBOUNCE_SAMPLES = 4;

	////////////////////////////////////////////////////////////////////////
	// register window
	localparam logic [31:0] BCSR_WINDOW_BASE = 32'h0210_0000;
	localparam logic [31:0] BCSR_WINDOW_LAST = 32'h0210_7fff;
	localparam int WINDOW_LSB = 15;
	localparam int MIRROR_LSB = 5;
	localparam logic [31:0] HARD_RESET_CONFIG_OFS = 32'h0210_0000;
	localparam logic [31:0] MEMORY_ENABLE_OFS = 32'h0210_0004;
	localparam logic [31:0] BOARD_CONTROL_TWO_OFS = 32'h0210_0008;
	localparam logic [31:0] BOARD_CONTROL_THREE_OFS = 32'h0210_000c;
	localparam logic [31:0] LAMP_AND_MISC_OFS = 32'h0210_0010;

	////////////////////////////////////////////////////////////////////////
	// field positions within the upper half word (data bits 31:16)
	localparam int HALF_LSB = 16;
	localparam int FLASH_EN_BIT = 31;
	localparam int DRAM_EN_BIT = 30;
	localparam int SDRAM_EN_BIT = 29;
	localparam int PCCARD_EN_BIT = 28;
	localparam int OPTION_LSB = 28;
	localparam int JUMPER_BIT = 27;
	localparam int ABORT_STATE_BIT = 26;
	localparam int SOFT_STATE_BIT = 25;
	localparam int COMBO_STATE_BIT = 24;
	localparam int SIGNAL_LAMP_BIT = 31;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] HARD_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] SOFT_CONFIG_WORD = 16'h0000;
	localparam logic [3:0] MEMORY_ENABLE_RESET = 4'h0;

	typedef enum logic [1:0] {
		BTN_IDLE = 2'b00,
		BTN_ABORT = 2'b01,
		BTN_SOFT = 2'b10,
		BTN_HARD = 2'b11
	} button_mode_e;

endpackage

// ### verilog/button_debounce.sv
/*
 * debounce of one active-low pushbutton.
 * assumes a one-cycle sample enable from a divider; the input is synchronous to mclk_i.
 */
`timescale 1ns/1ps
module button_debounce import board_ctl_pkg::*; #(
	parameter int SAMPLES = DEBOUNCE_SAMPLES
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// sample enable and raw button
	input wire logic sample_en_i,
	input wire logic button_n_i,
	// debounced state, high while pressed
	output logic pressed_o
);

	typedef struct packed {
		logic [7:0] count;
		logic pressed;
	} debounce_s;

	debounce_s state_reg;
	debounce_s state_next;

	always_comb begin
		state_next = state_reg;
		if (sample_en_i) begin
			if (~button_n_i == state_reg.pressed) begin
				state_next.count = 8'h00;
			end else if (state_reg.count == 8'(SAMPLES - 1)) begin
				state_next.count = 8'h00;
				state_next.pressed = ~button_n_i;
			end else begin
				state_next.count = state_reg.count + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pressed_o = state_reg.pressed;

endmodule

// ### verilog/board_control_status_logic.sv
/*
 * board glue: button debounce and reset/interrupt generation, the control/status
 * register window, memory chip select steering, card buffer gating and lamps.
 * assumes the processor bus signals are synchronous to mclk_i and that the
 * processor's own reset pins tell when a reset sequence is in progress.
 */
//
// Behaviour
// - abort press drives the level-zero interrupt request low.
// - abort button is debounced; no register bit can mask it.
// - soft-reset button is debounced and drives soft reset; software cannot block it.
// - during soft reset the soft configuration word is driven for sampling.
// - both buttons held together give hard reset instead.
// - during hard reset the first register's configuration word is driven.
// - four option switch lines are readable as a field.
// - run lamp lit only when selected debug indication reads zero.
// - auxiliary lamp follows signal lamp bit of fifth register.
// - flash enable routes chip select zero to flash, else to expansion.
// - dram enable routes chip selects two and three to dram, else off-board.
// - sdram enable routes chip select four to sdram, else to expansion.
// - card enabled drives address and strobe buffers and lights lamp.
// - card data buffers on only while a card enable strobe is low.
// - card status driven when enabled; address, data and status buffers off when disabled, direction still follows write.
// - registers claimed in the window 02100000 to 02107fff, 32-bit port.
// - five registers at consecutive word slots.
// - upper address bits ignored, registers mirror every 0x20 bytes.
// - only data bits 31:16 carry register contents.
`timescale 1ns/1ps
module board_control_status_logic import board_ctl_pkg::*; #(
	parameter int SAMPLE_CYCLES = DEBOUNCE_SAMPLE_CYCLES,
	parameter int SAMPLES = DEBOUNCE_SAMPLES,
	parameter logic [15:0] HARD_CONFIG_INIT = HARD_CONFIG_RESET,
	parameter logic [15:0] SOFT_CONFIG = SOFT_CONFIG_WORD
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// pushbuttons and switches
	input wire logic abort_button_n_i,
	input wire logic soft_reset_button_n_i,
	input wire logic [3:0] option_switch_lines_i,
	input wire logic debug_source_jumper_i,
	// debug state from the processor
	input wire logic visibility_status_zero_i,
	input wire logic visibility_status_one_i,
	input wire logic freeze_indication_i,
	// processor reset and interrupt
	input wire logic proc_hreset_n_i,
	input wire logic proc_sreset_n_i,
	output logic irq_level0_n_o,
	output logic hard_reset_n_o,
	output logic soft_reset_n_o,
	// processor register bus
	input wire logic bcsr_select_n_i,
	input wire logic [31:0] address_i,
	input wire logic write_n_i,
	input wire logic read_n_i,
	input wire logic [31:0] data_i,
	output logic [31:0] data_o,
	output logic data_oe_o,
	output logic xfer_ack_n_o,
	// memory chip selects from the processor
	input wire logic chip_select_zero_n_i,
	input wire logic chip_select_two_n_i,
	input wire logic chip_select_three_n_i,
	input wire logic chip_select_four_n_i,
	// chip selects to on-board memories
	output logic flash_cs_n_o,
	output logic dram_cs2_n_o,
	output logic dram_cs3_n_o,
	output logic sdram_cs_n_o,
	// chip selects to the expansion connectors
	output logic exp_cs0_n_o,
	output logic exp_cs2_n_o,
	output logic exp_cs3_n_o,
	output logic exp_cs4_n_o,
	// card buffers
	input wire logic card_enable_low_n_i,
	input wire logic card_enable_high_n_i,
	output logic card_addr_oe_o,
	output logic card_data_oe_o,
	output logic card_data_to_card_o,
	output logic card_status_oe_o,
	// lamps, high lights
	output logic run_lamp_o,
	output logic auxiliary_lamp_o,
	output logic flash_lamp_o,
	output logic dram_lamp_o,
	output logic sdram_lamp_o,
	output logic pc_card_lamp_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic slot_hit(input logic [31:0] addr, input logic [31:0] ofs);
		slot_hit = addr[MIRROR_LSB-1:0] == ofs[MIRROR_LSB-1:0];
	endfunction

	function automatic logic [31:0] upper_half(input logic [15:0] value);
		upper_half = {value, 16'h0000};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [31:0] tick_count;
		logic sample_en;
		button_mode_e mode;
		logic [15:0] hard_config;
		logic flash_en;
		logic dram_en;
		logic sdram_en;
		logic pccard_en;
		logic [15:0] scratch;
		logic signal_lamp;
		logic busy;
		logic ack;
		logic [31:0] data;
		logic data_oe;
		logic run_lamp;
		logic irq_n;
		logic hard_n;
		logic soft_n;
	} board_s;

	board_s state_reg;
	board_s state_next;
	logic abort_pressed;
	logic soft_pressed;
	logic window_hit;
	logic access_start;
	logic is_read;
	logic debug_active;
	logic [31:0] read_word;

	////////////////////////////////////////////////////////////////////////
	// button debounce

	button_debounce #(
		.SAMPLES(SAMPLES)
	) abort_debounce (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.sample_en_i(state_reg.sample_en),
		.button_n_i(abort_button_n_i),
		.pressed_o(abort_pressed)
	);

	button_debounce #(
		.SAMPLES(SAMPLES)
	) soft_debounce (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.sample_en_i(state_reg.sample_en),
		.button_n_i(soft_reset_button_n_i),
		.pressed_o(soft_pressed)
	);

	////////////////////////////////////////////////////////////////////////
	// register decode

	assign window_hit = ~bcsr_select_n_i &&
		address_i[31:WINDOW_LSB] == BCSR_WINDOW_BASE[31:WINDOW_LSB];
	assign access_start = window_hit && !state_reg.busy && (!read_n_i || !write_n_i);
	assign is_read = !read_n_i;

	// debug state per jumper: high selects the freeze line
	assign debug_active = debug_source_jumper_i ? freeze_indication_i
		: (visibility_status_zero_i | visibility_status_one_i);

	always_comb begin
		read_word = 32'h0000_0000;
		if (slot_hit(address_i, HARD_RESET_CONFIG_OFS)) begin
			read_word = upper_half(state_reg.hard_config);
		end else if (slot_hit(address_i, MEMORY_ENABLE_OFS)) begin
			read_word[FLASH_EN_BIT] = state_reg.flash_en;
			read_word[DRAM_EN_BIT] = state_reg.dram_en;
			read_word[SDRAM_EN_BIT] = state_reg.sdram_en;
			read_word[PCCARD_EN_BIT] = state_reg.pccard_en;
		end else if (slot_hit(address_i, BOARD_CONTROL_TWO_OFS)) begin
			read_word[OPTION_LSB +: 4] = option_switch_lines_i;
			read_word[JUMPER_BIT] = debug_source_jumper_i;
			read_word[ABORT_STATE_BIT] = abort_pressed;
			read_word[SOFT_STATE_BIT] = soft_pressed;
			read_word[COMBO_STATE_BIT] = state_reg.mode == BTN_HARD;
		end else if (slot_hit(address_i, BOARD_CONTROL_THREE_OFS)) begin
			read_word = upper_half(state_reg.scratch);
		end else if (slot_hit(address_i, LAMP_AND_MISC_OFS)) begin
			read_word[SIGNAL_LAMP_BIT] = state_reg.signal_lamp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_next = state_reg;

		// sample enable divider for debounce
		state_next.sample_en = 1'b0;
		if (state_reg.tick_count == 32'(SAMPLE_CYCLES - 1)) begin
			state_next.tick_count = 32'h0000_0000;
			state_next.sample_en = 1'b1;
		end else begin
			state_next.tick_count = state_reg.tick_count + 32'h0000_0001;
		end

		// button mode; the combination is held until both are released
		case (state_reg.mode)
			BTN_IDLE: begin
				if (abort_pressed && soft_pressed) begin
					state_next.mode = BTN_HARD;
				end else if (abort_pressed) begin
					state_next.mode = BTN_ABORT;
				end else if (soft_pressed) begin
					state_next.mode = BTN_SOFT;
				end
			end
			BTN_ABORT: begin
				if (abort_pressed && soft_pressed) begin
					state_next.mode = BTN_HARD;
				end else if (!abort_pressed) begin
					state_next.mode = BTN_IDLE;
				end
			end
			BTN_SOFT: begin
				if (abort_pressed && soft_pressed) begin
					state_next.mode = BTN_HARD;
				end else if (!soft_pressed) begin
					state_next.mode = BTN_IDLE;
				end
			end
			BTN_HARD: begin
				if (!abort_pressed && !soft_pressed) begin
					state_next.mode = BTN_IDLE;
				end
			end
			default: begin
				state_next.mode = BTN_IDLE;
			end
		endcase

		// reset and interrupt outputs follow the mode, no register can gate them
		state_next.irq_n = !(state_next.mode == BTN_ABORT);
		state_next.soft_n = !(state_next.mode == BTN_SOFT);
		state_next.hard_n = !(state_next.mode == BTN_HARD);

		// bus access: one take per select assertion, ack one cycle later
		state_next.ack = 1'b0;
		if (!window_hit) begin
			state_next.busy = 1'b0;
		end
		if (access_start) begin
			state_next.busy = 1'b1;
			state_next.ack = 1'b1;
			if (!is_read) begin
				if (slot_hit(address_i, HARD_RESET_CONFIG_OFS)) begin
					state_next.hard_config = data_i[31:HALF_LSB];
				end else if (slot_hit(address_i, MEMORY_ENABLE_OFS)) begin
					state_next.flash_en = data_i[FLASH_EN_BIT];
					state_next.dram_en = data_i[DRAM_EN_BIT];
					state_next.sdram_en = data_i[SDRAM_EN_BIT];
					state_next.pccard_en = data_i[PCCARD_EN_BIT];
				end else if (slot_hit(address_i, BOARD_CONTROL_THREE_OFS)) begin
					state_next.scratch = data_i[31:HALF_LSB];
				end else if (slot_hit(address_i, LAMP_AND_MISC_OFS)) begin
					state_next.signal_lamp = data_i[SIGNAL_LAMP_BIT];
				end
			end
		end

		// data bus: reset configuration has priority over read data
		if (!proc_hreset_n_i) begin
			state_next.data = upper_half(state_reg.hard_config);
			state_next.data_oe = 1'b1;
		end else if (!proc_sreset_n_i) begin
			state_next.data = upper_half(SOFT_CONFIG);
			state_next.data_oe = 1'b1;
		end else if (access_start && is_read) begin
			state_next.data = read_word;
			state_next.data_oe = 1'b1;
		end else if (!(window_hit && is_read && state_reg.busy)) begin
			state_next.data_oe = 1'b0;
		end

		state_next.run_lamp = !debug_active;
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= '0;
			state_reg.mode <= BTN_IDLE;
			state_reg.hard_config <= HARD_CONFIG_INIT;
			{state_reg.flash_en, state_reg.dram_en, state_reg.sdram_en, state_reg.pccard_en} <=
				MEMORY_ENABLE_RESET;
			state_reg.irq_n <= 1'b1;
			state_reg.hard_n <= 1'b1;
			state_reg.soft_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign irq_level0_n_o = state_reg.irq_n;
	assign hard_reset_n_o = state_reg.hard_n;
	assign soft_reset_n_o = state_reg.soft_n;
	assign data_o = state_reg.data;
	assign data_oe_o = state_reg.data_oe;
	assign xfer_ack_n_o = !state_reg.ack;

	// chip select steering
	assign flash_cs_n_o = chip_select_zero_n_i | !state_reg.flash_en;
	assign exp_cs0_n_o = chip_select_zero_n_i | state_reg.flash_en;
	assign dram_cs2_n_o = chip_select_two_n_i | !state_reg.dram_en;
	assign dram_cs3_n_o = chip_select_three_n_i | !state_reg.dram_en;
	assign exp_cs2_n_o = chip_select_two_n_i | state_reg.dram_en;
	assign exp_cs3_n_o = chip_select_three_n_i | state_reg.dram_en;
	assign sdram_cs_n_o = chip_select_four_n_i | !state_reg.sdram_en;
	assign exp_cs4_n_o = chip_select_four_n_i | state_reg.sdram_en;

	// card buffers
	assign card_addr_oe_o = state_reg.pccard_en;
	assign card_data_oe_o = state_reg.pccard_en &&
		(!card_enable_low_n_i || !card_enable_high_n_i);
	assign card_data_to_card_o = !write_n_i;
	assign card_status_oe_o = state_reg.pccard_en;

	// lamps
	assign run_lamp_o = state_reg.run_lamp;
	assign auxiliary_lamp_o = state_reg.signal_lamp;
	assign flash_lamp_o = state_reg.flash_en;
	assign dram_lamp_o = state_reg.dram_en;
	assign sdram_lamp_o = state_reg.sdram_en;
	assign pc_card_lamp_o = state_reg.pccard_en;

endmodule

// ### tb/board_ctl_monitor.sv
/* checker for the board control/status logic: bus answer, steering, lamps, buttons.
   assumes one clock mclk_i with synchronous reset_i; bound to the top module. */
`timescale 1ns/1ps
module board_ctl_monitor import board_ctl_pkg::*; #(
	parameter int SAMPLE_CYCLES = DEBOUNCE_SAMPLE_CYCLES,
	parameter int SAMPLES = DEBOUNCE_SAMPLES
) (
	// clock, reset, abort button, debug state
	input wire logic mclk_i, reset_i, abort_button_n_i, debug_source_jumper_i,
	input wire logic visibility_status_zero_i, visibility_status_one_i, freeze_indication_i,
	// resets, interrupt, register bus
	input wire logic irq_level0_n_o, hard_reset_n_o, soft_reset_n_o,
	input wire logic bcsr_select_n_i, write_n_i, read_n_i, xfer_ack_n_o,
	input wire logic [31:0] address_i,
	// chip selects
	input wire logic chip_select_zero_n_i, chip_select_two_n_i, chip_select_three_n_i, chip_select_four_n_i,
	input wire logic flash_cs_n_o, dram_cs2_n_o, dram_cs3_n_o, sdram_cs_n_o,
	input wire logic exp_cs0_n_o, exp_cs2_n_o, exp_cs3_n_o, exp_cs4_n_o,
	// card and lamps
	input wire logic card_enable_low_n_i, card_enable_high_n_i, card_addr_oe_o, card_data_oe_o,
	input wire logic card_data_to_card_o, card_status_oe_o, run_lamp_o, auxiliary_lamp_o,
	input wire logic flash_lamp_o, dram_lamp_o, sdram_lamp_o, pc_card_lamp_o
);
	logic [31:0] abort_low_reg;
	logic in_win, acc_win, lamp_wr, dbg_sel;
	assign in_win = address_i[31:15] == 17'h0420;
	assign acc_win = !bcsr_select_n_i && in_win;
	assign lamp_wr = acc_win && !write_n_i && address_i[4:2] == 3'h4;
	assign dbg_sel = debug_source_jumper_i ? freeze_indication_i : (visibility_status_zero_i | visibility_status_one_i);
	// consecutive cycles the raw abort button has been low
	always_ff @(posedge mclk_i) begin
		if (reset_i || abort_button_n_i) begin
			abort_low_reg <= 32'h0000_0000;
		end else if (abort_low_reg != 32'h7fff_ffff) begin
			abort_low_reg <= abort_low_reg + 32'h0000_0001;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////
	sequence s_take;
		acc_win && !(read_n_i && write_n_i) && $past(bcsr_select_n_i);
	endsequence
	property p_take;
		s_take |=> !xfer_ack_n_o;
	endproperty
	a_take: assert property (p_take) else $error("window access not acknowledged");
	property p_ack_one;
		$fell(xfer_ack_n_o) |=> xfer_ack_n_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("acknowledge longer than one cycle");
	property p_ack_cause;
		!xfer_ack_n_o |-> $past(acc_win);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without window access");
	property p_flash;
		flash_cs_n_o == (chip_select_zero_n_i | !flash_lamp_o) && exp_cs0_n_o == (chip_select_zero_n_i | flash_lamp_o);
	endproperty
	a_flash: assert property (p_flash) else $error("flash select steering wrong");
	property p_dram;
		dram_cs2_n_o == (chip_select_two_n_i | !dram_lamp_o) && dram_cs3_n_o == (chip_select_three_n_i | !dram_lamp_o)
			&& exp_cs2_n_o == (chip_select_two_n_i | dram_lamp_o) && exp_cs3_n_o == (chip_select_three_n_i | dram_lamp_o);
	endproperty
	a_dram: assert property (p_dram) else $error("dram select steering wrong");
	property p_sdram;
		sdram_cs_n_o == (chip_select_four_n_i | !sdram_lamp_o) && exp_cs4_n_o == (chip_select_four_n_i | sdram_lamp_o);
	endproperty
	a_sdram: assert property (p_sdram) else $error("sdram select steering wrong");
	property p_card;
		card_addr_oe_o == pc_card_lamp_o && card_status_oe_o == pc_card_lamp_o && card_data_to_card_o == !write_n_i
			&& card_data_oe_o == (pc_card_lamp_o && !(card_enable_low_n_i && card_enable_high_n_i));
	endproperty
	a_card: assert property (p_card) else $error("card buffer gating wrong");
	property p_run;
		!$past(reset_i) |-> run_lamp_o == !$past(dbg_sel);
	endproperty
	a_run: assert property (p_run) else $error("run lamp wrong");
	property p_aux;
		$changed(auxiliary_lamp_o) |-> $past(lamp_wr);
	endproperty
	a_aux: assert property (p_aux) else $error("auxiliary lamp changed without write");
	property p_debounce;
		$fell(irq_level0_n_o) |-> int'(abort_low_reg) >= SAMPLE_CYCLES * (SAMPLES - 1);
	endproperty
	a_debounce: assert property (p_debounce) else $error("interrupt before abort settled");
	property p_combo;
		!hard_reset_n_o |-> irq_level0_n_o && soft_reset_n_o;
	endproperty
	a_combo: assert property (p_combo) else $error("separate action during hard reset");
endmodule

bind board_control_status_logic board_ctl_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .SAMPLES(SAMPLES))
	board_ctl_monitor_inst (.*);

// ### tb/board_bus_model.sv
/* processor bus model running register cycles toward the board logic.
   assumes the answer is a low acknowledge within eight cycles of the request. */
`timescale 1ns/1ps
module board_bus_model (
	// clock and answer
	input wire logic mclk_i,
	input wire logic xfer_ack_n_i,
	input wire logic [31:0] data_i,
	// cycle toward the device
	output logic bcsr_select_n_o,
	output logic write_n_o,
	output logic read_n_o,
	output logic [31:0] address_o,
	output logic [31:0] data_o
);
	initial begin
		bcsr_select_n_o = 1'b1;
		write_n_o = 1'b1;
		read_n_o = 1'b1;
		address_o = 32'h0;
		data_o = 32'h0;
	end
	task automatic access(input logic wr, input logic [31:0] addr, wdata, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0;
		@(negedge mclk_i);
		bcsr_select_n_o = 1'b0;
		address_o = addr;
		write_n_o = !wr;
		read_n_o = wr;
		data_o = wr ? wdata : ~data_o;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge mclk_i);
			if (xfer_ack_n_i === 1'b0) begin
				ok = 1'b1;
				q = data_i;
			end
		end
		// released lines show no stale value
		@(negedge mclk_i);
		bcsr_select_n_o = 1'b1;
		write_n_o = 1'b1;
		read_n_o = 1'b1;
		address_o = ~address_o;
		data_o = ~data_o;
		@(negedge mclk_i);
	endtask
endmodule

// ### tb/tb.sv
/* self-checking bench for the board control/status logic.
   assumes a short debounce (4 cycle sample, 2 samples) and the bus model beside it. */
`timescale 1ns/1ps
module tb;
	import board_ctl_pkg::*;
	logic mclk_i = 1'b0, reset_i = 1'b1, abort_button_n_i = 1'b1, soft_reset_button_n_i = 1'b1;
	logic [3:0] option_switch_lines_i = 4'h0;
	logic debug_source_jumper_i = 1'b0, visibility_status_zero_i = 1'b0, visibility_status_one_i = 1'b0;
	logic freeze_indication_i = 1'b0, proc_hreset_n_i = 1'b1, proc_sreset_n_i = 1'b1;
	logic chip_select_zero_n_i = 1'b1, chip_select_two_n_i = 1'b1, chip_select_three_n_i = 1'b1;
	logic chip_select_four_n_i = 1'b1, card_enable_low_n_i = 1'b1, card_enable_high_n_i = 1'b1;
	logic bcsr_select_n_i, write_n_i, read_n_i, data_oe_o, xfer_ack_n_o;
	logic irq_level0_n_o, hard_reset_n_o, soft_reset_n_o;
	logic [31:0] address_i, data_i, data_o;
	logic flash_cs_n_o, dram_cs2_n_o, dram_cs3_n_o, sdram_cs_n_o, exp_cs0_n_o, exp_cs2_n_o, exp_cs3_n_o, exp_cs4_n_o;
	logic card_addr_oe_o, card_data_oe_o, card_data_to_card_o, card_status_oe_o;
	logic run_lamp_o, auxiliary_lamp_o, flash_lamp_o, dram_lamp_o, sdram_lamp_o, pc_card_lamp_o;
	int failures = 0;
	int compares = 0;
	board_control_status_logic #(.SAMPLE_CYCLES(4), .SAMPLES(2), .HARD_CONFIG_INIT(16'hc381), .SOFT_CONFIG(16'h5a3c))
		board_control_status_logic_inst (.mclk_i, .reset_i, .abort_button_n_i, .soft_reset_button_n_i,
		.option_switch_lines_i, .debug_source_jumper_i, .visibility_status_zero_i, .visibility_status_one_i,
		.freeze_indication_i, .proc_hreset_n_i, .proc_sreset_n_i, .irq_level0_n_o, .hard_reset_n_o,
		.soft_reset_n_o, .bcsr_select_n_i, .address_i, .write_n_i, .read_n_i, .data_i, .data_o, .data_oe_o,
		.xfer_ack_n_o, .chip_select_zero_n_i, .chip_select_two_n_i, .chip_select_three_n_i, .chip_select_four_n_i,
		.flash_cs_n_o, .dram_cs2_n_o, .dram_cs3_n_o, .sdram_cs_n_o, .exp_cs0_n_o, .exp_cs2_n_o, .exp_cs3_n_o,
		.exp_cs4_n_o, .card_enable_low_n_i, .card_enable_high_n_i, .card_addr_oe_o, .card_data_oe_o,
		.card_data_to_card_o, .card_status_oe_o, .run_lamp_o, .auxiliary_lamp_o, .flash_lamp_o, .dram_lamp_o,
		.sdram_lamp_o, .pc_card_lamp_o);
	board_bus_model board_bus_model_inst (.mclk_i, .xfer_ack_n_i(xfer_ack_n_o), .data_i(data_o),
		.bcsr_select_n_o(bcsr_select_n_i), .write_n_o(write_n_i), .read_n_o(read_n_i), .address_o(address_i),
		.data_o(data_i));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic rd(input logic [31:0] addr, exp, input logic ack_exp = 1'b1);
		logic [31:0] q;
		logic ok;
		board_bus_model_inst.access(1'b0, addr, 32'h0, q, ok);
		chk({31'h0, ok}, {31'h0, ack_exp});
		if (ack_exp) chk(q, exp);
	endtask
	task automatic wr(input logic [31:0] addr, d);
		logic [31:0] q;
		logic ok;
		board_bus_model_inst.access(1'b1, addr, d, q, ok);
		chk({31'h0, ok}, 32'h1);
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		rd(32'h0210_0000, 32'hc381_0000);
		wr(32'h0210_0000, 32'h9e61_ffff);
		rd(32'h0210_0000, 32'h9e61_0000);
		rd(32'h0210_7fe0, 32'h9e61_0000);
		wr(32'h0210_002c, 32'h1234_5678);
		rd(32'h0210_000c, 32'h1234_0000);
		rd(32'h0210_0014, 32'h0);
		rd(32'h0210_8000, 32'h0, 1'b0);
		rd(32'h020f_fffc, 32'h0, 1'b0);
		wr(32'h0210_0000, 32'hc381_0000);
		$display("t_regs done");
	endtask
	task automatic t_options();
		logic [31:0] q;
		logic ok;
		for (int i = 0; i < 32; i++) begin
			{option_switch_lines_i, debug_source_jumper_i} = i[4:0];
			board_bus_model_inst.access(1'b0, 32'h0210_0008, 32'h0, q, ok);
			chk({27'h0, q[31:27]}, {27'h0, i[4:0]});
		end
		$display("t_options done");
	endtask
	task automatic t_lamps();
		for (int i = 0; i < 16; i++) begin
			{debug_source_jumper_i, visibility_status_zero_i, visibility_status_one_i, freeze_indication_i} = i[3:0];
			settle(2);
			chk({31'h0, run_lamp_o}, {31'h0, i[3] ? !i[0] : !(i[2] | i[1])});
		end
		wr(32'h0210_0010, 32'h8000_0000);
		chk({31'h0, auxiliary_lamp_o}, 32'h1);
		wr(32'h0210_0030, 32'h7fff_ffff);
		chk({31'h0, auxiliary_lamp_o}, 32'h0);
		$display("t_lamps done");
	endtask
	task automatic t_chipsel();
		for (int e = 0; e < 16; e++) begin
			wr(32'h0210_0004, {e[3:0], 28'h0});
			{chip_select_zero_n_i, chip_select_two_n_i, chip_select_three_n_i, chip_select_four_n_i} = 4'h0;
			{card_enable_low_n_i, card_enable_high_n_i} = e[2:1];
			#1;
			chk({28'h0, flash_cs_n_o, dram_cs2_n_o, dram_cs3_n_o, sdram_cs_n_o}, {28'h0, ~e[3], ~e[2], ~e[2], ~e[1]});
			chk({28'h0, exp_cs0_n_o, exp_cs2_n_o, exp_cs3_n_o, exp_cs4_n_o}, {28'h0, e[3], e[2], e[2], e[1]});
			chk({28'h0, flash_lamp_o, dram_lamp_o, sdram_lamp_o, pc_card_lamp_o}, {28'h0, e[3:0]});
			chk({29'h0, card_addr_oe_o, card_status_oe_o, card_data_oe_o}, {29'h0, e[0], e[0], e[0] & !(e[1] & e[2])});
			chk({31'h0, card_data_to_card_o}, 32'h0);
			{chip_select_zero_n_i, chip_select_two_n_i, chip_select_three_n_i, chip_select_four_n_i} = 4'hf;
		end
		$display("t_chipsel done");
	endtask
	task automatic t_buttons();
		wr(32'h0210_0004, 32'hffff_ffff);
		abort_button_n_i = 1'b0;
		settle(40);
		chk({29'h0, irq_level0_n_o, soft_reset_n_o, hard_reset_n_o}, 32'h3);
		abort_button_n_i = 1'b1;
		soft_reset_button_n_i = 1'b0;
		settle(40);
		chk({29'h0, irq_level0_n_o, soft_reset_n_o, hard_reset_n_o}, 32'h5);
		proc_sreset_n_i = 1'b0;
		settle(2);
		chk(data_o, 32'h5a3c_0000);
		chk({31'h0, data_oe_o}, 32'h1);
		proc_sreset_n_i = 1'b1;
		soft_reset_button_n_i = 1'b1;
		settle(40);
		{abort_button_n_i, soft_reset_button_n_i} = 2'b00;
		settle(40);
		chk({29'h0, irq_level0_n_o, soft_reset_n_o, hard_reset_n_o}, 32'h6);
		soft_reset_button_n_i = 1'b1;
		settle(40);
		chk({29'h0, irq_level0_n_o, soft_reset_n_o, hard_reset_n_o}, 32'h6);
		rd(32'h0210_0008, 32'hfd00_0000);
		proc_hreset_n_i = 1'b0;
		settle(2);
		chk(data_o, 32'hc381_0000);
		{proc_hreset_n_i, abort_button_n_i} = 2'b11;
		settle(40);
		chk({29'h0, irq_level0_n_o, soft_reset_n_o, hard_reset_n_o}, 32'h7);
		rd(32'h0210_0004, 32'hf000_0000);
		$display("t_buttons done");
	endtask
	////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge mclk_i);
		reset_i = 1'b0;
		t_regs();
		t_options();
		t_lamps();
		t_chipsel();
		t_buttons();
		end_of_test();
	end
	initial begin
		#200000;
		failures++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
